// [src/acr_defs.vh]
// constants for the converter configuration and status register bank
// assumes byte addressing on a 32-bit Avalon-MM slave, one word per index
//
// Summary of operation
// - read-only 24-bit strobe edge position status
// - 16-bit span code, reset 0xA000, all channels
// - span code maps 0x2000/0xA000/0xFFFF to 500/800/1000 mV
// - power code 0x46 low power, 0x4B default
// - timestamp bit 0 enables the input receiver
// - timestamp bit 1 selects PECL mode, no bias
// - 4-bit field selects strobe sampling delay
`ifndef ACR_DEFS_VH
`define ACR_DEFS_VH

// ==========================================================
// register indices, byte address is four times the index
`define ACR_IDX_DELAY_SEL   7'h29
`define ACR_IDX_EDGE_POS    7'h2C
`define ACR_IDX_SPAN        7'h30
`define ACR_IDX_POWER_ONE   7'h37
`define ACR_IDX_TIMESTAMP   7'h3B
`define ACR_IDX_CONTROL     7'h50

// ==========================================================
// widths and reset values
`define ACR_POS_W           24
`define ACR_SPAN_W          16
`define ACR_BYTE_W          8
`define ACR_SEL_W           4
`define ACR_RST_POS         24'h000000
`define ACR_RST_SPAN        16'hA000
`define ACR_RST_POWER       8'h4B
`define ACR_RST_TIMESTAMP   8'h00
`define ACR_RST_SEL         4'h0
`define ACR_RST_CTRL        2'h0

// ==========================================================
// field positions
`define ACR_TS_RECV_BIT     0
`define ACR_TS_PECL_BIT     1
`define ACR_CTRL_CAL_BIT    0
`define ACR_CTRL_LINK_BIT   1
`define ACR_CTRL_CALREQ_BIT 4
`define ACR_CTRL_ORDER_BIT  5

// ==========================================================
// power mode codes
`define ACR_PWR_LOW         8'h46
`define ACR_PWR_HIGH        8'h4B

// ==========================================================
// span code to millivolt mapping
`define ACR_SPAN_MID_CODE   16'hA000
`define ACR_SPAN_MIN_CODE   16'h2000
`define ACR_SPAN_MID_MV     10'h320
`define ACR_SPAN_LO_SLOPE   9'h12C
`define ACR_SPAN_LO_SHIFT   15
`define ACR_SPAN_HI_SLOPE   14'h2157
`define ACR_SPAN_HI_SHIFT   20

`endif

// [src/acr_field_reg.v]
// one read-write configuration field with byte-merged write
// assumes the caller has already merged byte lanes into wrData
`timescale 1ns/1ns
`default_nettype none

module acr_field_reg #(
  parameter             WIDTH = 8,
  parameter [WIDTH-1:0] RESET = {WIDTH{1'b0}}
) (
  // clock and reset
  input  wire             core_clk,
  input  wire             rst,
  // write side
  input  wire             wrEn,
  input  wire [WIDTH-1:0] wrData,
  // stored value
  output reg  [WIDTH-1:0] q
);

  // ==========================================================
  // storage
  always @(posedge core_clk) begin
    if (rst) begin
      q <= RESET;
    end else if (wrEn) begin
      q <= wrData;
    end
  end

endmodule // acr_field_reg

`default_nettype wire

// [src/acr_regs.v]
// configuration and status register bank of the converter
// assumes an Avalon-MM master on core_clk and a position
// detector that presents its result with a valid strobe
`timescale 1ns/1ns
`default_nettype none
`include "acr_defs.vh"

module acr_regs (
  // clock and reset
  input  wire        core_clk,
  input  wire        rst,
  // avalon-mm slave
  input  wire [8:0]  avs_address,
  input  wire        avs_read,
  input  wire        avs_write,
  input  wire [31:0] avs_writedata,
  input  wire [3:0]  avs_byteenable,
  output reg  [31:0] avs_readdata,
  output reg         avs_waitrequest,
  // strobe position detector
  input  wire [23:0] strobeEdgePosIn,
  input  wire        strobePosValid,
  // analog and link controls
  output wire [3:0]  strobeDelaySelect,
  output wire [15:0] inputSpanCode,
  output reg  [9:0]  inputSpanMv,
  output wire [7:0]  powerModeCode,
  output reg         lowPowerActive,
  output reg         powerModeReserved,
  output reg         timestampReceiverEnable,
  output reg         timestampPeclMode,
  output reg         calEnable,
  output reg         serialLinkEnable
);

  // ==========================================================
  // bus handshake
  wire        busReq;
  wire        busDone;
  wire [6:0]  regIdx;
  wire [31:0] byteMask;

  assign busReq   = avs_read | avs_write;
  assign busDone  = busReq & ~avs_waitrequest;
  assign regIdx   = avs_address[8:2];
  assign byteMask = {{8{avs_byteenable[3]}}, {8{avs_byteenable[2]}},
                     {8{avs_byteenable[1]}}, {8{avs_byteenable[0]}}};

  // first cycle drops waitrequest, second completes the access
  always @(posedge core_clk) begin
    if (rst) begin
      avs_waitrequest <= 1'b1;
    end else if (busDone) begin
      avs_waitrequest <= 1'b1;
    end else if (busReq) begin
      avs_waitrequest <= 1'b0;
    end else begin
      avs_waitrequest <= 1'b1;
    end
  end

  // ==========================================================
  // write strobes
  wire        wrAccept;
  wire        wrSel;
  wire        wrSpan;
  wire        wrPower;
  wire        wrStamp;
  wire        wrCtrl;

  assign wrAccept = busDone & avs_write;
  assign wrSel    = wrAccept & (regIdx == `ACR_IDX_DELAY_SEL);
  assign wrSpan   = wrAccept & (regIdx == `ACR_IDX_SPAN);
  assign wrPower  = wrAccept & (regIdx == `ACR_IDX_POWER_ONE);
  assign wrStamp  = wrAccept & (regIdx == `ACR_IDX_TIMESTAMP);
  assign wrCtrl   = wrAccept & (regIdx == `ACR_IDX_CONTROL);

  // ==========================================================
  // byte-merged write data
  wire [31:0] curSel;
  wire [31:0] curSpan;
  wire [31:0] curPower;
  wire [31:0] curCtrl;
  wire [31:0] mrgSel;
  wire [31:0] mrgSpan;
  wire [31:0] mrgPower;
  wire [31:0] mrgStamp;
  wire [31:0] mrgCtrl;
  reg  [7:0]  stampQ;

  assign curSel   = {28'h0000000, strobeDelaySelect};
  assign curSpan  = {16'h0000, inputSpanCode};
  assign curPower = {24'h000000, powerModeCode};
  assign curCtrl  = {30'h0, serialLinkEnable, calEnable};
  assign mrgSel   = (curSel & ~byteMask) | (avs_writedata & byteMask);
  assign mrgSpan  = (curSpan & ~byteMask) | (avs_writedata & byteMask);
  assign mrgPower = (curPower & ~byteMask) | (avs_writedata & byteMask);
  assign mrgStamp = ({24'h000000, stampQ} & ~byteMask) |
                    (avs_writedata & byteMask);
  assign mrgCtrl  = (curCtrl & ~byteMask) | (avs_writedata & byteMask);

  // ==========================================================
  // strobe edge position status
  reg  [23:0] edgePosQ;

  // only the detector updates it; bus writes never reach it
  always @(posedge core_clk) begin
    if (rst) begin
      edgePosQ <= `ACR_RST_POS;
    end else if (strobePosValid) begin
      edgePosQ <= strobeEdgePosIn;
    end
  end

  // ==========================================================
  // strobe delay select
  acr_field_reg #(
    .WIDTH (`ACR_SEL_W),
    .RESET (`ACR_RST_SEL)
  ) u_delaySel (
    .core_clk (core_clk),
    .rst      (rst),
    .wrEn     (wrSel),
    .wrData   (mrgSel[3:0]),
    .q        (strobeDelaySelect)
  );

  // ==========================================================
  // input span code, one setting for all channels
  acr_field_reg #(
    .WIDTH (`ACR_SPAN_W),
    .RESET (`ACR_RST_SPAN)
  ) u_span (
    .core_clk (core_clk),
    .rst      (rst),
    .wrEn     (wrSpan),
    .wrData   (mrgSpan[15:0]),
    .q        (inputSpanCode)
  );

  // piecewise linear span in millivolts, low codes still accepted
  wire [15:0] spanLoDiff;
  wire [15:0] spanHiDiff;
  wire [24:0] spanLoProd;
  wire [29:0] spanHiProd;
  wire [9:0]  spanLoMv;
  wire [9:0]  spanHiMv;

  assign spanLoDiff = `ACR_SPAN_MID_CODE - inputSpanCode;
  assign spanHiDiff = inputSpanCode - `ACR_SPAN_MID_CODE;
  assign spanLoProd = spanLoDiff * `ACR_SPAN_LO_SLOPE;
  assign spanHiProd = spanHiDiff * `ACR_SPAN_HI_SLOPE;
  assign spanLoMv   = `ACR_SPAN_MID_MV -
                      spanLoProd[`ACR_SPAN_LO_SHIFT+9:`ACR_SPAN_LO_SHIFT];
  assign spanHiMv   = `ACR_SPAN_MID_MV +
                      spanHiProd[`ACR_SPAN_HI_SHIFT+9:`ACR_SPAN_HI_SHIFT];

  always @(posedge core_clk) begin
    if (rst) begin
      inputSpanMv <= `ACR_SPAN_MID_MV;
    end else if (inputSpanCode < `ACR_SPAN_MID_CODE) begin
      inputSpanMv <= spanLoMv;
    end else begin
      inputSpanMv <= spanHiMv;
    end
  end

  // ==========================================================
  // power mode code
  acr_field_reg #(
    .WIDTH (`ACR_BYTE_W),
    .RESET (`ACR_RST_POWER)
  ) u_power (
    .core_clk (core_clk),
    .rst      (rst),
    .wrEn     (wrPower),
    .wrData   (mrgPower[7:0]),
    .q        (powerModeCode)
  );

  // decode of the stored code; reserved codes keep high performance
  always @(posedge core_clk) begin
    if (rst) begin
      lowPowerActive    <= 1'b0;
      powerModeReserved <= 1'b0;
    end else begin
      lowPowerActive    <= (powerModeCode == `ACR_PWR_LOW);
      powerModeReserved <= (powerModeCode != `ACR_PWR_LOW) &&
                           (powerModeCode != `ACR_PWR_HIGH);
    end
  end

  // ==========================================================
  // timestamp input control, reserved bits stored and read back
  always @(posedge core_clk) begin
    if (rst) begin
      stampQ                  <= `ACR_RST_TIMESTAMP;
      timestampReceiverEnable <= 1'b0;
      timestampPeclMode       <= 1'b0;
    end else begin
      if (wrStamp) begin
        stampQ <= mrgStamp[7:0];
      end
      timestampReceiverEnable <= stampQ[`ACR_TS_RECV_BIT];
      timestampPeclMode       <= stampQ[`ACR_TS_PECL_BIT];
    end
  end

  // ==========================================================
  // calibration and link enables with ordering status
  reg  calNeededQ;
  reg  orderErrQ;
  wire modeChange;
  wire orderViolation;
  wire clrCalNeeded;
  wire clrOrderErr;

  // only a changed code calls for a fresh calibration
  assign modeChange     = wrPower & (mrgPower[7:0] != powerModeCode);
  assign orderViolation = wrPower & (calEnable | serialLinkEnable);
  assign clrCalNeeded   = wrCtrl & avs_byteenable[0] &
                          avs_writedata[`ACR_CTRL_CALREQ_BIT];
  assign clrOrderErr    = wrCtrl & avs_byteenable[0] &
                          avs_writedata[`ACR_CTRL_ORDER_BIT];

  always @(posedge core_clk) begin
    if (rst) begin
      calEnable        <= 1'b0;
      serialLinkEnable <= 1'b0;
      calNeededQ       <= 1'b0;
      orderErrQ        <= 1'b0;
    end else begin
      if (wrCtrl) begin
        calEnable        <= mrgCtrl[`ACR_CTRL_CAL_BIT];
        serialLinkEnable <= mrgCtrl[`ACR_CTRL_LINK_BIT];
      end
      // set wins over a clear in the same cycle
      if (modeChange) begin
        calNeededQ <= 1'b1;
      end else if (clrCalNeeded) begin
        calNeededQ <= 1'b0;
      end
      if (orderViolation) begin
        orderErrQ <= 1'b1;
      end else if (clrOrderErr) begin
        orderErrQ <= 1'b0;
      end
    end
  end

  // ==========================================================
  // read data, loaded as waitrequest drops
  reg [31:0] rdMux;

  always @* begin
    case (regIdx)
      `ACR_IDX_DELAY_SEL: begin
        rdMux = curSel;
      end
      `ACR_IDX_EDGE_POS: begin
        rdMux = {8'h00, edgePosQ};
      end
      `ACR_IDX_SPAN: begin
        rdMux = curSpan;
      end
      `ACR_IDX_POWER_ONE: begin
        rdMux = curPower;
      end
      `ACR_IDX_TIMESTAMP: begin
        rdMux = {24'h000000, stampQ};
      end
      `ACR_IDX_CONTROL: begin
        rdMux = {26'h0, orderErrQ, calNeededQ,
                 2'h0, serialLinkEnable, calEnable};
      end
      default: begin
        rdMux = 32'h00000000;
      end
    endcase
  end

  always @(posedge core_clk) begin
    if (rst) begin
      avs_readdata <= 32'h00000000;
    end else if (avs_read & avs_waitrequest) begin
      avs_readdata <= rdMux;
    end
  end

endmodule // acr_regs

`default_nettype wire

// [test/acr_regs_checker.sv]
// assertions on the ports of the register bank
// assumes it is bound onto acr_regs, one clock, sync reset
`timescale 1ns/1ns
`default_nettype none
`include "acr_defs.vh"

module acr_regs_checker (
  // clock and reset
  input wire logic        core_clk,
  input wire logic        rst,
  // register bus
  input wire logic [8:0]  avs_address,
  input wire logic        avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0]  avs_byteenable,
  input wire logic        avs_waitrequest,
  // controls
  input wire logic [3:0]  strobeDelaySelect,
  input wire logic [15:0] inputSpanCode,
  input wire logic [9:0]  inputSpanMv,
  input wire logic [7:0]  powerModeCode,
  input wire logic        lowPowerActive,
  input wire logic        powerModeReserved,
  input wire logic        timestampReceiverEnable,
  input wire logic        timestampPeclMode
);
  // ==========================================================
  // completed write with the low lane enabled
  wire       wrDone = avs_write & ~avs_waitrequest & avs_byteenable[0];
  wire [6:0] wrIdx  = avs_address[8:2];

  default clocking @(posedge core_clk); endclocking
  default disable iff (rst);

  // ==========================================================
  // reset values
  span_reset_a: assert property (
    $fell(rst) |-> inputSpanCode == `ACR_RST_SPAN)
    else $error("span code not at reset value");
  power_reset_a: assert property (
    $fell(rst) |-> powerModeCode == `ACR_RST_POWER && !lowPowerActive)
    else $error("power code not at reset value");
  ts_reset_a: assert property (
    $fell(rst) |-> !timestampReceiverEnable && !timestampPeclMode)
    else $error("timestamp controls not cleared");

  // ==========================================================
  // writes reach the controls
  span_write_a: assert property (
    wrDone && wrIdx == `ACR_IDX_SPAN && avs_byteenable[1]
    |=> inputSpanCode == $past(avs_writedata[15:0]))
    else $error("span code did not take write");
  sel_write_a: assert property (
    wrDone && wrIdx == `ACR_IDX_DELAY_SEL
    |=> strobeDelaySelect == $past(avs_writedata[3:0]))
    else $error("delay select did not take write");
  ts_recv_a: assert property (
    wrDone && wrIdx == `ACR_IDX_TIMESTAMP |-> ##2
    timestampReceiverEnable == $past(avs_writedata[0], 2))
    else $error("receiver enable wrong after write");
  ts_pecl_a: assert property (
    wrDone && wrIdx == `ACR_IDX_TIMESTAMP |-> ##2
    timestampPeclMode == $past(avs_writedata[1], 2))
    else $error("pecl mode wrong after write");

  // ==========================================================
  // decodes and span mapping
  low_decode_a: assert property (
    lowPowerActive == ($past(powerModeCode) == `ACR_PWR_LOW))
    else $error("low power decode wrong");
  rsvd_decode_a: assert property (
    powerModeReserved == ($past(powerModeCode) != `ACR_PWR_LOW &&
    $past(powerModeCode) != `ACR_PWR_HIGH))
    else $error("reserved code decode wrong");
  mv_min_a: assert property (
    inputSpanCode == 16'h2000 |=> inputSpanMv == 10'h1F4)
    else $error("span not 500 mV");
  mv_max_a: assert property (
    inputSpanCode == 16'hFFFF |=> inputSpanMv == 10'h3E8)
    else $error("span not 1000 mV");

  cover property (lowPowerActive);
  cover property (timestampPeclMode);
  cover property (inputSpanMv == 10'h3E8);
endmodule // acr_regs_checker

bind acr_regs acr_regs_checker acr_regs_checker_i (
  .core_clk(core_clk), .rst(rst), .avs_address(avs_address),
  .avs_write(avs_write), .avs_writedata(avs_writedata),
  .avs_byteenable(avs_byteenable), .avs_waitrequest(avs_waitrequest),
  .strobeDelaySelect(strobeDelaySelect), .inputSpanCode(inputSpanCode),
  .inputSpanMv(inputSpanMv), .powerModeCode(powerModeCode),
  .lowPowerActive(lowPowerActive), .powerModeReserved(powerModeReserved),
  .timestampReceiverEnable(timestampReceiverEnable),
  .timestampPeclMode(timestampPeclMode));
`default_nettype wire

// [test/tb_adc_config_status_regs.sv]
// self-checking bench for the register bank
// assumes acr_regs behind an avalon-mm slave on one clock
`timescale 1ns/1ns
`default_nettype none
`include "acr_defs.vh"

module tb_adc_config_status_regs;
  // ==========================================================
  // stimulus and observed outputs
  logic        coreClk = 1'b0;
  logic        rst = 1'b1;
  logic [8:0]  avsAddress = 9'h000;
  logic        avsRead = 1'b0;
  logic        avsWrite = 1'b0;
  logic [31:0] avsWdata = 32'h0;
  logic [3:0]  avsBe = 4'hF;
  logic [23:0] posIn = 24'h0;
  logic        posValid = 1'b0;
  logic [31:0] rdData;
  logic        waitReq, lowPwr, pwrRsvd, tsRecv, tsPecl, calEn, linkEn;
  logic [3:0]  delaySel;
  logic [15:0] spanCode;
  logic [9:0]  spanMv;
  logic [7:0]  pwrCode;
  int          mismatches = 0;
  int          samplesChecked = 0;

  always #2 coreClk = ~coreClk;

  acr_regs acr_regs_i (
    .core_clk(coreClk), .rst(rst), .avs_address(avsAddress),
    .avs_read(avsRead), .avs_write(avsWrite), .avs_writedata(avsWdata),
    .avs_byteenable(avsBe), .avs_readdata(rdData),
    .avs_waitrequest(waitReq), .strobeEdgePosIn(posIn),
    .strobePosValid(posValid), .strobeDelaySelect(delaySel),
    .inputSpanCode(spanCode), .inputSpanMv(spanMv),
    .powerModeCode(pwrCode), .lowPowerActive(lowPwr),
    .powerModeReserved(pwrRsvd), .timestampReceiverEnable(tsRecv),
    .timestampPeclMode(tsPecl), .calEnable(calEn),
    .serialLinkEnable(linkEn));

  // ==========================================================
  // shared tasks
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    samplesChecked++;
    if (seen !== exp) begin
      mismatches++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  // one access, held until waitrequest is sampled low
  task automatic bus(input logic wr, input logic [6:0] idx,
      input logic [31:0] d, input logic [3:0] be, output logic [31:0] r);
    avsRead <= ~wr;
    avsWrite <= wr;
    avsAddress <= {idx, 2'b00};
    avsWdata <= d;
    avsBe <= be;
    do @(posedge coreClk); while (waitReq !== 1'b0);
    r = rdData;
    avsRead <= 1'b0;
    avsWrite <= 1'b0;
    repeat (2) @(posedge coreClk);
  endtask

  task automatic wr(input logic [6:0] idx, input logic [31:0] d);
    logic [31:0] r;
    bus(1'b1, idx, d, 4'hF, r);
  endtask

  task automatic rdc(input logic [6:0] idx, input logic [31:0] exp);
    logic [31:0] r;
    bus(1'b0, idx, 32'h0, 4'hF, r);
    chk(r, exp);
  endtask

  task automatic doReset();
    rst <= 1'b1;
    repeat (12) @(posedge coreClk);
    rst <= 1'b0;
    repeat (2) @(posedge coreClk);
  endtask

  // ==========================================================
  // scenarios
  task automatic tResetVals();
    rdc(`ACR_IDX_SPAN, 32'h0000A000);
    rdc(`ACR_IDX_POWER_ONE, 32'h0000004B);
    rdc(`ACR_IDX_TIMESTAMP, 32'h00000000);
    rdc(`ACR_IDX_EDGE_POS, 32'h00000000);
    rdc(`ACR_IDX_DELAY_SEL, 32'h00000000);
    rdc(`ACR_IDX_CONTROL, 32'h00000000);
    chk(32'({calEn, linkEn, lowPwr, pwrRsvd, tsRecv, tsPecl}), 32'h0);
    chk(32'(spanMv), 32'h00000320);
  endtask

  task automatic tSpan();
    logic [15:0] codes [3] = '{16'h2000, 16'hA000, 16'hFFFF};
    logic [9:0]  mvs [3] = '{10'h1F4, 10'h320, 10'h3E8};
    logic [31:0] r;
    for (int i = 0; i < 3; i++) begin
      wr(`ACR_IDX_SPAN, 32'(codes[i]));
      chk(32'({spanCode, 6'h00, spanMv}), {codes[i], 6'h00, mvs[i]});
    end
    bus(1'b1, `ACR_IDX_SPAN, 32'hFFFF0034, 4'h1, r);
    rdc(`ACR_IDX_SPAN, 32'h0000FF34);
  endtask

  task automatic tPower();
    logic [7:0] codes [3] = '{8'h46, 8'h4B, 8'h55};
    logic [1:0] flags [3] = '{2'h2, 2'h0, 2'h1};
    wr(`ACR_IDX_CONTROL, 32'h00000000);
    for (int i = 0; i < 3; i++) begin
      wr(`ACR_IDX_POWER_ONE, 32'(codes[i]));
      chk(32'({pwrCode, lowPwr, pwrRsvd}), 32'({codes[i], flags[i]}));
      rdc(`ACR_IDX_POWER_ONE, 32'(codes[i]));
    end
  endtask

  // enables, order error and calibration request flags
  task automatic tCtrl();
    wr(`ACR_IDX_CONTROL, 32'h00000033);
    chk(32'({linkEn, calEn}), 32'h00000003);
    rdc(`ACR_IDX_CONTROL, 32'h00000003);
    wr(`ACR_IDX_POWER_ONE, 32'h00000046);
    rdc(`ACR_IDX_CONTROL, 32'h00000033);
    wr(`ACR_IDX_CONTROL, 32'h00000030);
    wr(`ACR_IDX_POWER_ONE, 32'h00000046);
    rdc(`ACR_IDX_CONTROL, 32'h00000000);
    wr(`ACR_IDX_POWER_ONE, 32'h0000004B);
    rdc(`ACR_IDX_CONTROL, 32'h00000010);
    wr(`ACR_IDX_CONTROL, 32'h00000011);
    chk(32'({linkEn, calEn}), 32'h00000001);
    rdc(`ACR_IDX_CONTROL, 32'h00000001);
  endtask

  task automatic tStamp();
    for (int v = 3; v >= 0; v--) begin
      wr(`ACR_IDX_TIMESTAMP, 32'(v[1:0]));
      chk(32'({tsPecl, tsRecv}), 32'(v[1:0]));
      rdc(`ACR_IDX_TIMESTAMP, 32'(v[1:0]));
    end
  endtask

  task automatic tPos();
    logic [31:0] r;
    posIn <= 24'hABCDEF;
    posValid <= 1'b1;
    @(posedge coreClk);
    posValid <= 1'b0;
    posIn <= 24'h543210;
    @(posedge coreClk);
    rdc(`ACR_IDX_EDGE_POS, 32'h00ABCDEF);
    wr(`ACR_IDX_EDGE_POS, 32'hFFFFFFFF);
    rdc(`ACR_IDX_EDGE_POS, 32'h00ABCDEF);
    bus(1'b0, `ACR_IDX_EDGE_POS, 32'h0, 4'hF, r);
    wr(`ACR_IDX_DELAY_SEL, {28'h0, r[3:0]});
    chk(32'(delaySel), 32'h0000000F);
    rdc(7'h10, 32'h00000000);
  endtask

  // ==========================================================
  // run control
  task automatic conclude();
    $display("mismatches=%0d samples_checked=%0d", mismatches,
      samplesChecked);
    if (mismatches == 0 && samplesChecked > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  initial begin
    repeat (20000) @(posedge coreClk);
    mismatches++;
    conclude();
  end

  initial begin
    doReset();
    tResetVals();
    tSpan();
    tPower();
    tCtrl();
    tStamp();
    tPos();
    doReset();
    tResetVals();
    conclude();
  end
endmodule // tb_adc_config_status_regs
`default_nettype wire
